// ===== include/fpc_params.svh
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH
// clock rate and timing figures
`define FPC_CLK_MHZ 20
`define FPC_POR_US 100
`define FPC_STATUS_LOW_US 300
`define FPC_INIT_US 200
`define FPC_CD2CU_NS 40
`define FPC_USER_INIT_EDGES 8576
// axi4-lite map, byte addresses
`define FPC_ADDR_W 8
`define FPC_A_CTRL 8'h00
`define FPC_A_LEN 8'h04
`define FPC_A_KEY 8'h08
`define FPC_A_UIO 8'h0C
`define FPC_A_STATE 8'h10
`define FPC_A_COUNT 8'h14
`define FPC_A_CHECK 8'h18
`define FPC_RESP_OK 2'h0
`define FPC_RESP_ERR 2'h2
// control field positions and reset value
`define FPC_F_WIDTH 1:0
`define FPC_F_DECOMP 2
`define FPC_F_CRYPT 3
`define FPC_F_INITPIN 4
`define FPC_F_USRCLK 5
`define FPC_F_DUALIO 6
`define FPC_CTRL_RST 32'h00000000
`define FPC_LEN_RST 32'h00000001
`endif

// ===== include/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
	typedef enum logic [7:0] {
		ST_POR = 8'h01,
		ST_RESET = 8'h02,
		ST_SWAIT = 8'h04,
		ST_LOAD = 8'h08,
		ST_TAIL = 8'h10,
		ST_DONEW = 8'h20,
		ST_INIT = 8'h40,
		ST_USER = 8'h80
	} fpc_state_type;
	typedef enum logic [1:0] {
		W_8 = 2'h0,
		W_16 = 2'h1,
		W_32 = 2'h2
	} fpc_width_type;
endpackage
`default_nettype wire

// ===== logic/fpc_sync3.sv
`include "fpc_params.svh"
`default_nettype none
// three-stage pin synchroniser; output moves only when stages two and three agree
module fpc_sync3 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_ff, s2_ff, s3_ff, q_ff;
			// stage one feeds only stage two, never any gate
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					q_ff <= 1'b0;
				end else if (ce) begin
					s1_ff <= d[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff)
						q_ff <= s3_ff;
				end
			end
			assign q[i] = q_ff;
		end
	endgenerate
endmodule
`default_nettype wire

// ===== logic/fpc_ratio.sv
`include "fpc_params.svh"
`default_nettype none
// clocks per data word for the chosen bus width and features
module fpc_ratio (
	input wire logic [1:0] width,
	input wire logic decomp,
	input wire logic crypt,
	output logic [3:0] ratio
);
	always_comb begin
		case (fpc_pkg::fpc_width_type'(width))
			fpc_pkg::W_8: ratio = decomp ? 4'h2 : 4'h1;
			fpc_pkg::W_16: ratio = decomp ? 4'h4 : (crypt ? 4'h2 : 4'h1);
			fpc_pkg::W_32: ratio = decomp ? 4'h8 : (crypt ? 4'h4 : 4'h1);
			default: ratio = 4'h1;
		endcase
	end
endmodule
`default_nettype wire

// ===== logic/fpc_loader.sv
// How it works
// - byte mode: one clock, two when decompressing
// - 16-bit mode: ratios one, two, four
// - 32-bit mode: ratios one, four, eight
// - spare clocks decrypt and decompress words; here decompression only consumes them
// - narrow modes use only low data bits
// - data pins become user I/O afterwards
// - user mode all high; restart low reconfigures
// - status held low for power-on delay
// - load-complete low until image received
// - config clock ignored after configuration
// - load-complete rises only after whole image
// - init pin low until initialization ends
// - restart drives both lines low quickly
// - status low 268 to 1506 microseconds
// - words sampled on rising config clock
// - oscillator init takes 175 to 437 us
// - user clock init: delay then 8576 edges
`include "fpc_params.svh"
`default_nettype none
module fpc_loader #(
	parameter int POR_CYC = `FPC_POR_US * `FPC_CLK_MHZ,
	parameter int STATUS_LOW_CYC = `FPC_STATUS_LOW_US * `FPC_CLK_MHZ,
	parameter int USER_INIT_EDGES = `FPC_USER_INIT_EDGES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [`FPC_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`FPC_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic config_clock,
	input wire logic restart_req_n,
	input wire logic user_init_clock,
	input wire logic [31:0] data_i,
	output logic [31:0] data_o,
	output logic [31:0] data_oe,
	input wire logic status_n_i,
	output logic status_n_o,
	output logic status_n_oe,
	input wire logic conf_done_i,
	output logic conf_done_o,
	output logic conf_done_oe,
	output logic init_done_n,
	output logic [31:0] proc_word,
	output logic proc_valid
);
	localparam int INIT_CYC = `FPC_INIT_US * `FPC_CLK_MHZ;
	localparam int CD2CU_CYC = (`FPC_CD2CU_NS * `FPC_CLK_MHZ + 999) / 1000;

	fpc_pkg::fpc_state_type state_ff;
	logic [15:0] timer_ff, edge_cnt_ff, low_cnt_ff;
	logic [1:0] fall_cnt_ff;
	logic [31:0] ctrl_ff, len_ff, key_ff, uio_ff;
	logic [31:0] word_cnt_ff, hold_ff, check_ff, mask_ff;
	logic [3:0] slot_ff, ratio_ff, ratio_w;
	logic crypt_ff, initpin_ff, usrclk_ff;
	logic cclk_lvl, rst_lvl, ucl_lvl, stat_lvl, cdone_lvl;
	logic cclk_prev_ff, ucl_prev_ff;
	logic [31:0] data_lvl;
	logic rise, fall, ucl_rise, slot_last, last_cap, in_load;
	logic [31:0] lane_word, out_word;

	//////////////////////////////////////////////////////////////////
	// pin synchronisers and edge finding
	fpc_sync3 #(.W(5)) u_sync_ctl (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.d({config_clock, restart_req_n, user_init_clock, status_n_i, conf_done_i}),
		.q({cclk_lvl, rst_lvl, ucl_lvl, stat_lvl, cdone_lvl})
	);
	// data shares the clock's delay so a word lines up with its edge
	fpc_sync3 #(.W(32)) u_sync_data (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.d(data_i),
		.q(data_lvl)
	);
	fpc_ratio u_ratio (
		.width(ctrl_ff[`FPC_F_WIDTH]),
		.decomp(ctrl_ff[`FPC_F_DECOMP]),
		.crypt(ctrl_ff[`FPC_F_CRYPT]),
		.ratio(ratio_w)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cclk_prev_ff <= 1'b0;
			ucl_prev_ff <= 1'b0;
		end else if (ce) begin
			cclk_prev_ff <= cclk_lvl;
			ucl_prev_ff <= ucl_lvl;
		end
	end
	assign rise = cclk_lvl && !cclk_prev_ff;
	assign fall = !cclk_lvl && cclk_prev_ff;
	assign ucl_rise = ucl_lvl && !ucl_prev_ff;
	assign in_load = (state_ff == fpc_pkg::ST_LOAD) || (state_ff == fpc_pkg::ST_TAIL);
	assign slot_last = (slot_ff == ratio_ff - 4'h1);
	assign last_cap = (state_ff == fpc_pkg::ST_LOAD) && rise && (slot_ff == 4'h0) && (word_cnt_ff + 32'h1 >= len_ff);
	assign lane_word = data_lvl & mask_ff;
	// decrypt step: whitening with the key; decompression only consumes slots
	assign out_word = ((slot_ff == 4'h0) ? lane_word : hold_ff) ^ (crypt_ff ? (key_ff & mask_ff) : 32'h0);

	//////////////////////////////////////////////////////////////////
	// sequencing: power-up, restart, load, handshake, initialization
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= fpc_pkg::ST_POR;
			timer_ff <= 16'h0000;
			fall_cnt_ff <= 2'h0;
			edge_cnt_ff <= 16'h0000;
		end else if (ce) begin
			if (!rst_lvl && state_ff != fpc_pkg::ST_POR) begin
				state_ff <= fpc_pkg::ST_RESET;
				timer_ff <= 16'h0000;
			end else begin
				case (state_ff)
					fpc_pkg::ST_POR: begin
						timer_ff <= timer_ff + 16'h0001;
						if (timer_ff >= 16'(POR_CYC - 1)) begin
							state_ff <= fpc_pkg::ST_SWAIT;
							timer_ff <= 16'h0000;
						end
					end
					fpc_pkg::ST_RESET: begin
						state_ff <= fpc_pkg::ST_SWAIT;
						timer_ff <= 16'h0000;
					end
					fpc_pkg::ST_SWAIT: begin
						// the host may hold the status line low to stretch this phase
						if (timer_ff < 16'(STATUS_LOW_CYC))
							timer_ff <= timer_ff + 16'h0001;
						else if (stat_lvl)
							state_ff <= fpc_pkg::ST_LOAD;
					end
					fpc_pkg::ST_LOAD: begin
						// a ratio-one load skips the tail, so the falling-edge count is cleared here
						fall_cnt_ff <= 2'h0;
						if (last_cap)
							state_ff <= (ratio_ff == 4'h1) ? fpc_pkg::ST_DONEW : fpc_pkg::ST_TAIL;
					end
					fpc_pkg::ST_TAIL: begin
						if (rise && slot_last)
							state_ff <= fpc_pkg::ST_DONEW;
						fall_cnt_ff <= 2'h0;
					end
					fpc_pkg::ST_DONEW: begin
						// edges count only once the pin has really risen
						if (fall && cdone_lvl) begin
							fall_cnt_ff <= fall_cnt_ff + 2'h1;
							if (fall_cnt_ff == 2'h1) begin
								state_ff <= fpc_pkg::ST_INIT;
								timer_ff <= 16'h0000;
								edge_cnt_ff <= 16'h0000;
							end
						end
					end
					fpc_pkg::ST_INIT: begin
						if (timer_ff != 16'hFFFF)
							timer_ff <= timer_ff + 16'h0001;
						if (!usrclk_ff) begin
							if (timer_ff >= 16'(INIT_CYC - 1))
								state_ff <= fpc_pkg::ST_USER;
						end else if (timer_ff >= 16'(CD2CU_CYC) && ucl_rise) begin
							edge_cnt_ff <= edge_cnt_ff + 16'h0001;
							if (edge_cnt_ff >= 16'(USER_INIT_EDGES - 1))
								state_ff <= fpc_pkg::ST_USER;
						end
					end
					fpc_pkg::ST_USER: state_ff <= fpc_pkg::ST_USER;
					default: state_ff <= fpc_pkg::ST_POR;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// word reception; settings are frozen at the start of a load
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_cnt_ff <= 32'h0;
			slot_ff <= 4'h0;
			hold_ff <= 32'h0;
			check_ff <= 32'h0;
			ratio_ff <= 4'h1;
			mask_ff <= 32'h000000FF;
			crypt_ff <= 1'b0;
			initpin_ff <= 1'b0;
			usrclk_ff <= 1'b0;
			proc_word <= 32'h0;
			proc_valid <= 1'b0;
		end else if (ce) begin
			proc_valid <= 1'b0;
			if (state_ff == fpc_pkg::ST_RESET || state_ff == fpc_pkg::ST_SWAIT || state_ff == fpc_pkg::ST_POR) begin
				word_cnt_ff <= 32'h0;
				slot_ff <= 4'h0;
				check_ff <= 32'h0;
				ratio_ff <= ratio_w;
				crypt_ff <= ctrl_ff[`FPC_F_CRYPT];
				initpin_ff <= ctrl_ff[`FPC_F_INITPIN];
				usrclk_ff <= ctrl_ff[`FPC_F_USRCLK];
				case (fpc_pkg::fpc_width_type'(ctrl_ff[`FPC_F_WIDTH]))
					fpc_pkg::W_8: mask_ff <= 32'h000000FF;
					fpc_pkg::W_16: mask_ff <= 32'h0000FFFF;
					default: mask_ff <= 32'hFFFFFFFF;
				endcase
			end else if (in_load && rise) begin
				// the host spaces words by the ratio, so slot zero always holds a new word
				slot_ff <= slot_last ? 4'h0 : slot_ff + 4'h1;
				if (slot_ff == 4'h0 && state_ff == fpc_pkg::ST_LOAD) begin
					hold_ff <= lane_word;
					word_cnt_ff <= word_cnt_ff + 32'h1;
				end
				if (slot_last) begin
					proc_word <= out_word;
					proc_valid <= 1'b1;
					check_ff <= check_ff ^ out_word;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// open-drain control lines and dual-purpose data pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_n_o <= 1'b0;
			status_n_oe <= 1'b1;
			conf_done_o <= 1'b0;
			conf_done_oe <= 1'b1;
			init_done_n <= 1'b1;
			data_o <= 32'h0;
			data_oe <= 32'h0;
			low_cnt_ff <= 16'h0000;
		end else if (ce) begin
			status_n_o <= 1'b0;
			conf_done_o <= 1'b0;
			if (!rst_lvl && state_ff != fpc_pkg::ST_POR) begin
				status_n_oe <= 1'b1;
				conf_done_oe <= 1'b1;
			end else begin
				status_n_oe <= (state_ff == fpc_pkg::ST_POR) || (state_ff == fpc_pkg::ST_RESET) ||
					((state_ff == fpc_pkg::ST_SWAIT) && (timer_ff < 16'(STATUS_LOW_CYC)));
				conf_done_oe <= !(state_ff == fpc_pkg::ST_DONEW || state_ff == fpc_pkg::ST_INIT ||
					state_ff == fpc_pkg::ST_USER);
			end
			init_done_n <= !(initpin_ff && (in_load || state_ff == fpc_pkg::ST_DONEW ||
				state_ff == fpc_pkg::ST_INIT));
			data_o <= uio_ff;
			data_oe <= {32{(state_ff == fpc_pkg::ST_USER) && ctrl_ff[`FPC_F_DUALIO]}};
			// only read by the status width check below
			low_cnt_ff <= status_n_oe ? ((low_cnt_ff == 16'hFFFF) ? low_cnt_ff : low_cnt_ff + 16'h0001) : 16'h0000;
		end
	end

	//////////////////////////////////////////////////////////////////
	// axi4-lite slave; address and data may come in either order
	logic aw_held_ff, w_held_ff;
	logic [`FPC_ADDR_W-1:0] aw_addr_ff;
	logic [31:0] w_data_ff, wmask, rd_data;
	logic [3:0] w_strb_ff;
	logic rd_err;
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_strb
			assign wmask[8*b +: 8] = {8{w_strb_ff[b]}};
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `FPC_RESP_OK;
			aw_addr_ff <= '0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
			ctrl_ff <= `FPC_CTRL_RST;
			len_ff <= `FPC_LEN_RST;
			key_ff <= 32'h0;
			uio_ff <= 32'h0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= awaddr;
				awready <= 1'b0;
			end else if (!aw_held_ff)
				awready <= 1'b1;
			if (wvalid && wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= wdata;
				w_strb_ff <= wstrb;
				wready <= 1'b0;
			end else if (!w_held_ff)
				wready <= 1'b1;
			if (bvalid && bready)
				bvalid <= 1'b0;
			else if (aw_held_ff && w_held_ff && !bvalid) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid <= 1'b1;
				bresp <= `FPC_RESP_OK;
				case (aw_addr_ff)
					`FPC_A_CTRL: ctrl_ff <= (ctrl_ff & ~wmask) | (w_data_ff & wmask);
					`FPC_A_LEN: len_ff <= (len_ff & ~wmask) | (w_data_ff & wmask);
					`FPC_A_KEY: key_ff <= (key_ff & ~wmask) | (w_data_ff & wmask);
					`FPC_A_UIO: uio_ff <= (uio_ff & ~wmask) | (w_data_ff & wmask);
					default: bresp <= `FPC_RESP_ERR;
				endcase
			end
		end
	end

	// read decode
	always_comb begin
		rd_err = 1'b0;
		case (araddr)
			`FPC_A_CTRL: rd_data = ctrl_ff;
			`FPC_A_LEN: rd_data = len_ff;
			`FPC_A_KEY: rd_data = key_ff;
			`FPC_A_UIO: rd_data = uio_ff;
			`FPC_A_STATE: rd_data = {24'h0, state_ff};
			`FPC_A_COUNT: rd_data = word_cnt_ff;
			`FPC_A_CHECK: rd_data = check_ff;
			default: begin
				rd_data = 32'h0;
				rd_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `FPC_RESP_OK;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rd_err ? `FPC_RESP_ERR : `FPC_RESP_OK;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end else if (!rvalid)
				arready <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_restart;
		ce && !rst_lvl && state_ff != fpc_pkg::ST_POR;
	endsequence
	sequence s_lines_low;
		status_n_oe && conf_done_oe;
	endsequence

	a_restart_lines_low: assert property (s_restart |=> s_lines_low)
		else $error("restart did not pull both lines low");
	a_status_low_width: assert property ($fell(status_n_oe) |-> low_cnt_ff >= 16'(STATUS_LOW_CYC))
		else $error("status released too early");
	a_done_after_image: assert property ($fell(conf_done_oe) |-> word_cnt_ff >= len_ff)
		else $error("load-complete released before whole image");
	a_user_lines_high: assert property (state_ff == fpc_pkg::ST_USER |-> !status_n_oe && !conf_done_oe)
		else $error("user mode with a line held low");
	a_user_ignores_clock: assert property (state_ff == fpc_pkg::ST_USER && ce && rise |=> $stable(word_cnt_ff))
		else $error("clock edge counted in user mode");
	a_word_on_rise: assert property (state_ff == fpc_pkg::ST_LOAD && ce && rise && slot_ff == 4'h0
		|=> word_cnt_ff == $past(word_cnt_ff) + 32'h1)
		else $error("word not taken on rising edge");
	a_slot_in_ratio: assert property (in_load |-> slot_ff < ratio_ff && ratio_ff inside {4'h1, 4'h2, 4'h4, 4'h8})
		else $error("slot beyond clock ratio");
	a_two_falls_init: assert property (state_ff == fpc_pkg::ST_DONEW && ce && rst_lvl && fall && cdone_lvl
		&& fall_cnt_ff == 2'h1 |=> state_ff == fpc_pkg::ST_INIT)
		else $error("init not started after two falling edges");
	a_init_pin_low: assert property (initpin_ff && state_ff == fpc_pkg::ST_INIT ##1 state_ff == fpc_pkg::ST_INIT
		|-> !init_done_n)
		else $error("init pin released during initialization");
	a_narrow_lanes: assert property (proc_valid && mask_ff == 32'h000000FF |-> proc_word[31:8] == 24'h0)
		else $error("upper lanes used in byte mode");
endmodule
`default_nettype wire

// ===== tb/fpc_host.sv
`default_nettype none
// host model: a loader that owns the config clock, data bus and restart line
module fpc_host (
	input wire logic status_pin,
	input wire logic conf_done_pin,
	output logic config_clock,
	output logic [31:0] data_i,
	output logic restart_req_n,
	output logic user_init_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	// config clock rests low between frames, never left floating
	initial begin
		config_clock = 1'b0;
		data_i = 32'h00000000;
		restart_req_n = 1'b1;
		user_init_clock = 1'b0;
	end
	// free user init clock, 300 ns period, edges always on aclk falling edges
	always #150 user_init_clock <= ~user_init_clock;
	// n periods of 400 ns, far below the clock ceiling, even duty
	task automatic cycles(input int n);
		repeat (n) begin
			#200 config_clock <= 1'b1;
			#200 config_clock <= 1'b0;
		end
	endtask
	task automatic put(input logic [31:0] w);
		data_i <= w;
	endtask
	// hold time is over: show the inverse so a stale word cannot pass
	task automatic drop();
		data_i <= ~data_i;
	endtask
	// restart pulse of 2 us, then status release plus 2 us before any clock
	task automatic restart();
		restart_req_n <= 1'b0;
		#2000 restart_req_n <= 1'b1;
		wait (status_pin === 1'b1);
		#2000;
	endtask
	// two falling edges once load-complete reads high
	task automatic finish();
		wait (conf_done_pin === 1'b1);
		cycles(2);
	endtask
endmodule
`default_nettype wire

// ===== tb/fast_parallel_config_port_bench.sv
`include "fpc_params.svh"
`default_nettype none
module fast_parallel_config_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] KEY = 32'h0000003C;
	localparam logic [31:0] UIO = 32'h1234ABCD;
	localparam logic [7:0] CTRL_T [9] = '{8'h58, 8'h24, 8'h2C, 8'h29, 8'h2D, 8'h2A, 8'h16, 8'h62, 8'h21};
	localparam int RATIO_T [9] = '{1, 2, 2, 2, 4, 4, 8, 1, 1};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic ce = 1'b1;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, proc_valid, init_done_n, status_pin, conf_done_pin;
	logic status_n_oe, conf_done_oe, status_n_o, conf_done_o, config_clock, restart_req_n, user_init_clock;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, data_i, data_o, data_oe, proc_word;
	logic [31:0] got [$];
	int err_count = 0;
	int tests_run = 0;
	////////////////////////////////////////////////////////////////
	// clock, and open-drain lines with pull-ups: low only while driven
	always #25 aclk = ~aclk;
	assign status_pin = status_n_oe ? status_n_o : 1'b1;
	assign conf_done_pin = conf_done_oe ? conf_done_o : 1'b1;
	fpc_loader #(.POR_CYC(20), .STATUS_LOW_CYC(30), .USER_INIT_EDGES(4)) i_fpc_loader (
		.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .config_clock(config_clock), .restart_req_n(restart_req_n),
		.user_init_clock(user_init_clock), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
		.status_n_i(status_pin), .status_n_o(status_n_o), .status_n_oe(status_n_oe),
		.conf_done_i(conf_done_pin), .conf_done_o(conf_done_o), .conf_done_oe(conf_done_oe),
		.init_done_n(init_done_n), .proc_word(proc_word), .proc_valid(proc_valid));
	fpc_host i_fpc_host (
		.status_pin(status_pin), .conf_done_pin(conf_done_pin), .config_clock(config_clock),
		.data_i(data_i), .restart_req_n(restart_req_n), .user_init_clock(user_init_clock));
	// every processed word, in order of arrival
	always @(posedge aclk) begin
		if (proc_valid === 1'b1) begin
			got.push_back(proc_word);
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	// both channels offered together, each released at its own handshake
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check(32'(bresp), 32'(er));
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		check(d, exp);
		check(32'(r), 32'(er));
	endtask
	// both lines must be pulled low within 600 ns, twelve cycles
	task automatic restart_chk();
		fork
			i_fpc_host.restart();
			begin
				repeat (12) @(posedge aclk);
				check(32'({status_n_oe, conf_done_oe}), 32'h3);
			end
		join
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs well under a millisecond
	initial begin
		#3000000;
		err_count++;
		print_verdict();
	end
	initial begin
		logic [31:0] d, w, m, e, e0;
		logic [1:0] r;
		int n;
		realtime t0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// power-up: status held low through both delays, load-complete low
		n = 0;
		while (status_n_oe !== 1'b0 && n < 200) begin
			@(posedge aclk);
			check(32'(conf_done_oe), 32'h1);
			n++;
		end
		check(32'(n >= 50 && n < 60), 32'h1);
		rd_chk(`FPC_A_CTRL, `FPC_CTRL_RST, `FPC_RESP_OK);
		rd_chk(`FPC_A_LEN, `FPC_LEN_RST, `FPC_RESP_OK);
		rd_chk(8'h1C, 32'h00000000, `FPC_RESP_ERR);
		axi_wr(8'h1C, 32'h00000005, `FPC_RESP_ERR);
		axi_wr(`FPC_A_LEN, 32'h00000002, `FPC_RESP_OK);
		// byte strobes: the low lane keeps its value, the upper lanes take the new zeros
		axi_wr(`FPC_A_KEY, 32'h5A5A5A3C, `FPC_RESP_OK);
		wstrb <= 4'hE;
		axi_wr(`FPC_A_KEY, 32'h00000000, `FPC_RESP_OK);
		wstrb <= 4'hF;
		rd_chk(`FPC_A_KEY, KEY, `FPC_RESP_OK);
		axi_wr(`FPC_A_UIO, UIO, `FPC_RESP_OK);
		// clock enable low: a whole config clock pulse must leave no trace
		ce <= 1'b0;
		i_fpc_host.put(32'h000000A5);
		i_fpc_host.cycles(1);
		repeat (2) @(posedge aclk);
		ce <= 1'b1;
		repeat (8) @(posedge aclk);
		rd_chk(`FPC_A_COUNT, 32'h00000000, `FPC_RESP_OK);
		i_fpc_host.cycles(1);
		repeat (8) @(posedge aclk);
		rd_chk(`FPC_A_COUNT, 32'h00000001, `FPC_RESP_OK);
		// one two-word image for every width and clock ratio, nine settings in all
		for (int i = 0; i < 9; i++) begin
			axi_wr(`FPC_A_CTRL, {24'h000000, CTRL_T[i]}, `FPC_RESP_OK);
			restart_chk();
			if (i == 4) begin
				i_fpc_host.put(32'h5EED0001);
				i_fpc_host.cycles(1);
				restart_chk();
			end
			got.delete();
			check(32'(init_done_n), 32'(!CTRL_T[i][4]));
			m = (CTRL_T[i][1:0] == 2'h0) ? 32'h000000FF : (CTRL_T[i][1:0] == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
			e0 = 32'h00000000;
			for (int j = 0; j < 2; j++) begin
				w = 32'h96F0C3A5 + 32'(i * 16 + j);
				e = (w & m) ^ (CTRL_T[i][3] ? KEY : 32'h00000000);
				e0 = e0 ^ e;
				i_fpc_host.put(w);
				i_fpc_host.cycles(1);
				if (j == 1) begin
					repeat (8) @(posedge aclk);
					check(32'(conf_done_oe), 32'(RATIO_T[i] > 1));
				end
				i_fpc_host.cycles(RATIO_T[i] - 1);
				i_fpc_host.drop();
				repeat (8) @(posedge aclk);
				check(32'(got.size()), 32'(j + 1));
				check(got[j], e);
			end
			check(32'(conf_done_oe), 32'h0);
			rd_chk(`FPC_A_COUNT, 32'h00000002, `FPC_RESP_OK);
			rd_chk(`FPC_A_CHECK, e0, `FPC_RESP_OK);
			t0 = $realtime;
			i_fpc_host.finish();
			do axi_rd(`FPC_A_STATE, d, r); while (d !== {24'h000000, fpc_pkg::ST_USER});
			if (CTRL_T[i][4] && !CTRL_T[i][5]) begin
				check(32'($realtime - t0 >= 175000.0 && $realtime - t0 <= 437000.0), 32'h1);
			end
			check(32'({status_n_oe, conf_done_oe, init_done_n}), 32'h1);
			check(data_oe, CTRL_T[i][6] ? 32'hFFFFFFFF : 32'h00000000);
			check(data_o, UIO);
			i_fpc_host.cycles(3);
			repeat (8) @(posedge aclk);
			rd_chk(`FPC_A_COUNT, 32'h00000002, `FPC_RESP_OK);
			rd_chk(`FPC_A_STATE, {24'h000000, fpc_pkg::ST_USER}, `FPC_RESP_OK);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
